// File: design/arr_pkg.sv
// package: result register offsets, field positions and reset values
package arr_pkg;
    // register offsets on the host register port
    localparam logic [7:0] OFS_CHG_CUR_HIGH = 8'h19;
    localparam logic [7:0] OFS_CHG_CUR_LOW = 8'h1A;
    localparam logic [7:0] OFS_BUS_VOLT_HIGH = 8'h1B;
    localparam logic [7:0] OFS_BUS_VOLT_LOW = 8'h1C;
    localparam logic [7:0] OFS_BAT_VOLT_HIGH = 8'h1D;
    localparam logic [7:0] OFS_BAT_VOLT_LOW = 8'h1E;
    // field layout
    localparam int SIGN_BIT = 7;
    localparam int RESULT_BITS = 16;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    localparam logic [7:0] RESERVED_MASK = 8'h7F;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // channel indices
    localparam int CH_CHG_CUR = 0;
    localparam int CH_BUS_VOLT = 1;
    localparam int CH_BAT_VOLT = 2;
    localparam int NUM_CH = 3;
endpackage : arr_pkg

// File: design/arr_result_bank.sv
// result register bank: converter results readable by the host
//
// Operation
// - charge-current low byte, 1 mA lsb, reset zero
// - bus-voltage high byte, 256 mV lsb, reset zero
// - bus-voltage low byte, 1 mV lsb, reset zero
// - battery-voltage high byte, 256 mV lsb, reset zero
// - voltage results two's complement, bit 15 sign
// - charge-current high byte bit 7 reads zero
// - battery-voltage low byte, 1 mV lsb, reset zero
//
// each result is held as one 16-bit slot and read out a byte at a time;
// reading the high byte and then the low byte is not atomic, so a load
// landing between the two reads can tear the pair (software rereads)
// read data is registered: the answer shows one cycle after the strobe
// and then stands until the next read, so a slow host may still pick it
// watchdog expiry comes in only so that the hold can be checked
`timescale 1ns/1ns
`default_nettype none
module arr_result_bank
    import arr_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // register-reset command and watchdog expiry
    input wire logic reg_reset_cmd,
    input wire logic watchdog_expired,
    // converter results, one-cycle valid strobes
    input wire logic chg_cur_valid,
    input wire logic [15:0] charge_current_result,
    input wire logic bus_volt_valid,
    input wire logic [15:0] input_bus_voltage_result,
    input wire logic bat_volt_valid,
    input wire logic [15:0] battery_voltage_result,
    // host register port
    input wire logic host_rd,
    input wire logic host_wr,
    input wire logic [7:0] host_addr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    output logic host_rvalid
);
    // per-channel inputs gathered for the generate loop
    logic [NUM_CH-1:0] ch_load;
    logic [15:0] ch_in [NUM_CH];
    logic [15:0] ch_val [NUM_CH];
    logic [7:0] next_rdata;
    // whole-slot reset value, both bytes zero
    localparam logic [15:0] SLOT_RESET = {RESULT_RESET, RESULT_RESET};

    assign ch_load = {bat_volt_valid, bus_volt_valid, chg_cur_valid};
    assign ch_in[CH_CHG_CUR] = charge_current_result;
    assign ch_in[CH_BUS_VOLT] = input_bus_voltage_result;
    assign ch_in[CH_BAT_VOLT] = battery_voltage_result;

    // one slot per channel; watchdog deliberately not wired in
    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_slot
            arr_result_slot u_slot (
                .ref_clk(ref_clk),
                .sys_rst(sys_rst),
                .clear_cmd(reg_reset_cmd),
                .load(ch_load[g]),
                .new_value(ch_in[g]),
                .value(ch_val[g])
            );
        end
    endgenerate

    // read decode; host writes have no path into any slot
    always_comb begin
        next_rdata = UNMAPPED_READ;
        unique case (host_addr)
            OFS_CHG_CUR_HIGH: next_rdata = ch_val[CH_CHG_CUR][15:8] & RESERVED_MASK;
            OFS_CHG_CUR_LOW: next_rdata = ch_val[CH_CHG_CUR][7:0];
            OFS_BUS_VOLT_HIGH: next_rdata = ch_val[CH_BUS_VOLT][15:8];
            OFS_BUS_VOLT_LOW: next_rdata = ch_val[CH_BUS_VOLT][7:0];
            OFS_BAT_VOLT_HIGH: next_rdata = ch_val[CH_BAT_VOLT][15:8];
            OFS_BAT_VOLT_LOW: next_rdata = ch_val[CH_BAT_VOLT][7:0];
            default: next_rdata = UNMAPPED_READ;
        endcase
    end

    // read data registered, one cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            host_rdata <= RESULT_RESET;
            host_rvalid <= 1'b0;
        end else begin
            host_rvalid <= host_rd;
            // hold last data between reads
            if (host_rd) begin
                host_rdata <= next_rdata;
            end
        end
    end

    // assertions
    // byte read checks compare the answer with the converter input two cycles back, sign checks with the slot;
    // load checks tie each slot to its converter input, so together they
    // follow a result from its strobe to the host without a scoreboard

    clear_zeroes_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_reset_cmd ##1 (host_rd && host_addr == OFS_BUS_VOLT_LOW && !reg_reset_cmd)
        |=> host_rdata == RESULT_RESET)
        else $error("bus voltage low byte not cleared");
    clear_all_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        reg_reset_cmd |=> (ch_val[CH_CHG_CUR] == SLOT_RESET
            && ch_val[CH_BUS_VOLT] == SLOT_RESET && ch_val[CH_BAT_VOLT] == SLOT_RESET))
        else $error("result slot not cleared by command");
    reset_slots_a: assert property (@(posedge ref_clk)
        sys_rst |=> (ch_val[CH_CHG_CUR] == SLOT_RESET
            && ch_val[CH_BUS_VOLT] == SLOT_RESET && ch_val[CH_BAT_VOLT] == SLOT_RESET))
        else $error("result slot not zero after reset");
    // reset leaves the read port idle
    reset_port_a: assert property (@(posedge ref_clk)
        sys_rst |=> (host_rdata == RESULT_RESET && !host_rvalid))
        else $error("read port not idle after reset");

    reserved_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (host_rd && host_addr == OFS_CHG_CUR_HIGH) |=> !host_rdata[SIGN_BIT])
        else $error("reserved bit read as one");
    chg_low_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (chg_cur_valid && !reg_reset_cmd) ##1
        (host_rd && host_addr == OFS_CHG_CUR_LOW && !reg_reset_cmd && !chg_cur_valid)
        |=> host_rdata == $past(charge_current_result[7:0], 2))
        else $error("charge current low byte wrong");
    bus_high_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (bus_volt_valid && !reg_reset_cmd) ##1
        (host_rd && host_addr == OFS_BUS_VOLT_HIGH && !reg_reset_cmd && !bus_volt_valid)
        |=> host_rdata == $past(input_bus_voltage_result[15:8], 2))
        else $error("bus voltage high byte wrong");
    bus_low_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (bus_volt_valid && !reg_reset_cmd) ##1
        (host_rd && host_addr == OFS_BUS_VOLT_LOW && !reg_reset_cmd && !bus_volt_valid)
        |=> host_rdata == $past(input_bus_voltage_result[7:0], 2))
        else $error("bus voltage low byte wrong");
    bat_high_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (bat_volt_valid && !reg_reset_cmd) ##1
        (host_rd && host_addr == OFS_BAT_VOLT_HIGH && !reg_reset_cmd && !bat_volt_valid)
        |=> host_rdata == $past(battery_voltage_result[15:8], 2))
        else $error("battery high byte wrong");
    bat_low_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (bat_volt_valid && !reg_reset_cmd) ##1
        (host_rd && host_addr == OFS_BAT_VOLT_LOW && !reg_reset_cmd && !bat_volt_valid)
        |=> host_rdata == $past(battery_voltage_result[7:0], 2))
        else $error("battery low byte wrong");
    bus_sign_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (host_rd && host_addr == OFS_BUS_VOLT_HIGH)
        |=> host_rdata[SIGN_BIT] == $past(ch_val[CH_BUS_VOLT][RESULT_BITS-1]))
        else $error("bus voltage sign bit lost");
    bat_sign_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (host_rd && host_addr == OFS_BAT_VOLT_HIGH)
        |=> host_rdata[SIGN_BIT] == $past(ch_val[CH_BAT_VOLT][RESULT_BITS-1]))
        else $error("battery voltage sign bit lost");

    chg_load_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (chg_cur_valid && !reg_reset_cmd)
        |=> ch_val[CH_CHG_CUR] == $past(charge_current_result))
        else $error("charge current result not captured");
    bus_load_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (bus_volt_valid && !reg_reset_cmd)
        |=> ch_val[CH_BUS_VOLT] == $past(input_bus_voltage_result))
        else $error("bus voltage result not captured");
    bat_load_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (bat_volt_valid && !reg_reset_cmd)
        |=> ch_val[CH_BAT_VOLT] == $past(battery_voltage_result))
        else $error("battery voltage result not captured");

    // watchdog and writes leave slots alone
    hold_value_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!reg_reset_cmd && !bat_volt_valid && (watchdog_expired || host_wr))
        |=> $stable(ch_val[CH_BAT_VOLT]))
        else $error("battery result disturbed");
    hold_chg_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!reg_reset_cmd && !chg_cur_valid && (watchdog_expired || host_wr))
        |=> $stable(ch_val[CH_CHG_CUR]))
        else $error("charge current result disturbed");
    hold_bus_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (!reg_reset_cmd && !bus_volt_valid && (watchdog_expired || host_wr))
        |=> $stable(ch_val[CH_BUS_VOLT]))
        else $error("bus voltage result disturbed");

    // read answer one cycle later
    read_valid_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        host_rd |=> host_rvalid)
        else $error("read not answered");
    no_answer_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !host_rd |=> !host_rvalid)
        else $error("answer without a read");
    // read data stands between reads
    rdata_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !host_rd |=> $stable(host_rdata))
        else $error("read data moved without a read");
    // offsets outside the bank read zero
    unmapped_zero_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (host_rd && (host_addr < OFS_CHG_CUR_HIGH || host_addr > OFS_BAT_VOLT_LOW))
        |=> host_rdata == UNMAPPED_READ)
        else $error("unmapped offset read nonzero");

    // write data deliberately unused: the bank is read only
    logic unused_wdata;
    assign unused_wdata = ^host_wdata;
endmodule : arr_result_bank
`default_nettype wire

// File: design/arr_result_slot.sv
// one 16-bit result slot: capture, clear and hold
`timescale 1ns/1ns
`default_nettype none
module arr_result_slot
    import arr_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // control
    input wire logic clear_cmd,
    input wire logic load,
    input wire logic [15:0] new_value,
    // held result
    output logic [15:0] value
);
    // clear wins over a load in the same cycle; watchdog does not reach here
    always_ff @(posedge ref_clk) begin
        if (sys_rst || clear_cmd) begin
            value <= {RESULT_RESET, RESULT_RESET};
        end else if (load) begin
            value <= new_value;
        end
    end
endmodule : arr_result_slot
`default_nettype wire

// File: tb/arr_host_model.sv
// host model: register reads and ignored writes
`timescale 1ns/1ns
`default_nettype none
module arr_host_model (
    // clock
    input wire logic ref_clk,
    // register port
    output logic host_rd,
    output logic host_wr,
    output logic [7:0] host_addr,
    output logic [7:0] host_wdata,
    input wire logic [7:0] host_rdata,
    input wire logic host_rvalid
);
    // idle levels before the first access; this model is the only driver
    initial begin
        host_rd = 1'b0;
        host_wr = 1'b0;
        host_addr = 8'h00;
        host_wdata = 8'h00;
    end
    // one access; the answer settles one edge before the take
    task automatic access(input logic wr, input logic [7:0] a, output logic [7:0] q);
        @(posedge ref_clk);
        host_rd <= ~wr;
        host_wr <= wr;
        host_addr <= a;
        host_wdata <= ~a;
        @(posedge ref_clk);
        host_rd <= 1'b0;
        host_wr <= 1'b0;
        // released address flips so a stale offset is never reused
        host_addr <= ~a;
        @(posedge ref_clk);
        // taken at the edge where the one-cycle answer is sampled, before it drops
        q = host_rvalid ? host_rdata : 8'hXX;
    endtask : access
endmodule : arr_host_model
`default_nettype wire

// File: tb/arr_result_bank_test.sv
// self-checking bench for the result register bank
`timescale 1ns/1ns
`default_nettype none
module arr_result_bank_test;
    import arr_pkg::*;
    logic ref_clk, sys_rst, cmd, wdg, rd, wr, rvalid;
    logic [2:0] vld; // strobes: current, bus, battery
    logic [15:0] dc, db, dv, mc, mb, mv; // driven data and expected model
    logic [7:0] addr, wdata, rdata, q;
    int fail_count, checks_done, seed, cyc, i;
    arr_result_bank i_arr_result_bank (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .reg_reset_cmd(cmd), .watchdog_expired(wdg), .chg_cur_valid(vld[0]),
        .charge_current_result(dc), .bus_volt_valid(vld[1]), .input_bus_voltage_result(db),
        .bat_volt_valid(vld[2]), .battery_voltage_result(dv), .host_rd(rd), .host_wr(wr),
        .host_addr(addr), .host_wdata(wdata), .host_rdata(rdata), .host_rvalid(rvalid));
    arr_host_model i_arr_host_model (.ref_clk(ref_clk), .host_rd(rd), .host_wr(wr),
        .host_addr(addr), .host_wdata(wdata), .host_rdata(rdata), .host_rvalid(rvalid));
    // expected byte per offset from the held results
    function automatic logic [7:0] exp_byte(input logic [7:0] a);
        case (a)
            OFS_CHG_CUR_HIGH: exp_byte = mc[15:8] & RESERVED_MASK;
            OFS_CHG_CUR_LOW: exp_byte = mc[7:0];
            OFS_BUS_VOLT_HIGH: exp_byte = mb[15:8];
            OFS_BUS_VOLT_LOW: exp_byte = mb[7:0];
            OFS_BAT_VOLT_HIGH: exp_byte = mv[15:8];
            OFS_BAT_VOLT_LOW: exp_byte = mv[7:0];
            default: exp_byte = UNMAPPED_READ;
        endcase
    endfunction : exp_byte
    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done
    // write or read-and-compare every offset 18h..1Fh, unmapped ends included
    task automatic sweep(input logic w);
        for (int a = 8'h18; a < 8'h20; a++) begin
            logic [7:0] e;
            // a write gets no answer at all; a read returns the held byte
            e = w ? 8'hXX : exp_byte(8'(a));
            i_arr_host_model.access(w, 8'(a), q);
            checks_done++;
            if (q !== e) begin
                $display("[ERR] %0t access %h got %h", $time, a, q);
                fail_count++;
            end
        end
    endtask : sweep
    // one-cycle strobes on all channels, optionally with a clear beside them
    task automatic load(input logic [15:0] c, b, v, input logic clr);
        @(posedge ref_clk);
        vld <= 3'h7;
        cmd <= clr;
        dc <= c;
        db <= b;
        dv <= v;
        @(posedge ref_clk);
        vld <= 3'h0;
        cmd <= 1'b0;
        {mc, mb, mv} = clr ? 48'h0 : {c, b, v};
    endtask : load
    // random load, and a read taken at the very next edge behind it
    task automatic quick_read(input logic [7:0] a, input logic clr);
        fork
            load(16'($random(seed)), 16'($random(seed)), 16'($random(seed)), clr);
            begin
                @(posedge ref_clk);
                i_arr_host_model.access(1'b0, a, q);
            end
        join
        checks_done++;
        if (q !== exp_byte(a)) begin
            $display("[ERR] %0t quick read %h got %h", $time, a, q);
            fail_count++;
        end
    endtask : quick_read
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // hang guard, well above the run length
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            test_done;
        end
    end
    initial begin
        {sys_rst, cmd, wdg, vld, seed, cyc} = {1'b1, 5'h00, 32'd26707, 32'd0};
        {dc, db, dv, mc, mb, mv, fail_count, checks_done} = '0;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        sweep(1'b0);
        // sign and reserved-bit corners, then random codes
        load(16'hFFFF, 16'h8000, 16'h7FFF, 1'b0);
        sweep(1'b0);
        for (i = 0; i < 8; i++) begin
            load(16'($random(seed)), 16'($random(seed)), 16'($random(seed)), 1'b0);
            sweep(1'b0);
        end
        // reads right behind a load, one per result byte except the charge-current high byte
        for (i = 0; i < 5; i++) begin
            quick_read(8'(OFS_CHG_CUR_LOW + i), 1'b0);
        end
        // read right behind a clear
        quick_read(OFS_BUS_VOLT_LOW, 1'b1);
        // writes and watchdog leave results alone
        wdg <= 1'b1;
        sweep(1'b1);
        wdg <= 1'b0;
        sweep(1'b0);
        // clear wins over a load in the same cycle
        load(16'h1234, 16'h5678, 16'h9ABC, 1'b1);
        sweep(1'b0);
        // second reset in mid-run brings every byte back to zero
        load(16'hFFFF, 16'hFFFF, 16'hFFFF, 1'b0);
        sys_rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        {mc, mb, mv} = '0;
        sweep(1'b0);
        test_done;
    end
endmodule : arr_result_bank_test
`default_nettype wire
